// [logic/sroff_lock_qual.sv]
// Purpose: Qualifies lock of each digital PLL against its selected criterion
// Assumes: Phase error flags arrive asynchronously from the PLL cores
// Notes:   A criterion change restarts qualification
`timescale 1ns/1ns
`include "sroff_params.svh"
module sroff_lock_qual #(
    parameter int unsigned SHORT_CYCLES = `SROFF_LOCK_SHORT_CYC,
    parameter int unsigned LONG_CYCLES  = `SROFF_LOCK_LONG_CYC
)(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // Phase error flags from the PLLs
    input  wire logic [1:0] phase_ok_1us_pin,
    input  wire logic [1:0] phase_ok_10us_pin,
    // Criteria in, lock state out
    sroff_lock_if.qual      lk
);

    // ==============================================================
    // Elaboration check
    if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES || LONG_CYCLES > 32'h7FFFFFFF)
    begin : gen_bad_window
        $error("sroff_lock_qual: bad lock window lengths");
    end

    // ==============================================================
    // Two-stage synchronisers
    logic [1:0] ok1_meta_reg;
    logic [1:0] ok1_reg;
    logic [1:0] ok10_meta_reg;
    logic [1:0] ok10_reg;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ok1_meta_reg  <= 2'h0;
            ok1_reg       <= 2'h0;
            ok10_meta_reg <= 2'h0;
            ok10_reg      <= 2'h0;
        end
        else
        begin
            ok1_meta_reg  <= phase_ok_1us_pin;
            ok1_reg       <= ok1_meta_reg;
            ok10_meta_reg <= phase_ok_10us_pin;
            ok10_reg      <= ok10_meta_reg;
        end
    end

    // ==============================================================
    // One qualifier per PLL
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_pll
            sroff_pkg::sroff_qual_type state_reg;
            sroff_pkg::sroff_crit_type crit_prev_reg;
            logic [30:0]               count_reg;
            logic                      cond;
            logic [30:0]               target;

            // Condition and window picked by the criterion
            always_comb
            begin
                cond   = 1'b0;
                target = 31'(SHORT_CYCLES - 1);
                case (lk.criterion[g])
                    sroff_pkg::SROFF_CRIT_1US_1S:   cond = ok1_reg[g];
                    sroff_pkg::SROFF_CRIT_10US_1S:  cond = ok10_reg[g];
                    sroff_pkg::SROFF_CRIT_10US_10S:
                    begin
                        cond   = ok10_reg[g];
                        target = 31'(LONG_CYCLES - 1);
                    end
                    default:                        cond = 1'b0;
                endcase
            end

            // Lock when the condition holds for the whole window
            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    state_reg     <= sroff_pkg::SROFF_QUAL_HUNT;
                    crit_prev_reg <= sroff_pkg::SROFF_CRIT_RSVD;
                    count_reg     <= 31'h0;
                end
                else
                begin
                    crit_prev_reg <= lk.criterion[g];
                    if (!cond || crit_prev_reg != lk.criterion[g])
                    begin
                        state_reg <= sroff_pkg::SROFF_QUAL_HUNT;
                        count_reg <= 31'h0;
                    end
                    else
                    begin
                        case (state_reg)
                            sroff_pkg::SROFF_QUAL_HUNT:
                            begin
                                if (count_reg == target)
                                    state_reg <= sroff_pkg::SROFF_QUAL_LOCKED;
                                else
                                    count_reg <= count_reg + 31'h1;
                            end
                            sroff_pkg::SROFF_QUAL_LOCKED: state_reg <= state_reg;
                            default: state_reg <= sroff_pkg::SROFF_QUAL_HUNT;
                        endcase
                    end
                end
            end

            assign lk.locked[g] = (state_reg == sroff_pkg::SROFF_QUAL_LOCKED);
        end
    endgenerate

endmodule

// [logic/sroff_regs.sv]
// Purpose: Synthesizer ratio, PLL routing, output gate, lock criterion and
//          central frequency offset registers behind the paged byte port
// Assumes: Host byte strobes are synchronous to core_clk
// Notes:   Multi-byte values take effect only when every byte is written
//
// Operation
// R1: Ratio register holds denominator in bits 15:0, numerator in bits 31:16.
// R2: Synth frequency equals base frequency times multiplier times 16 times ratio.
// R3: Host programs numerator and denominator to one for plain rates; reset 0x00010001.
// R4: Routing bit 0 picks PLL 0 or PLL 1 for synthesizer 0.
// R5: Routing bit 2 picks PLL 0 or PLL 1 for synthesizer 1.
// R6: Host writes reserved bits back with their default values.
// R7: Gate bit 0 enables synthesizer 0 output, bit 1 synthesizer 1.
// R8: First PLL criterion in bits 1:0 picks phase error bound and hold time.
// R9: Second PLL criterion in bits 3:2 uses the same coding.
// R10: Selected criterion decides the lock indicator each PLL reports.
// R11: Offset is 32-bit two's complement, one step is 2^-32 of nominal.
// R12: One offset word applies to all four synthesizers together.
// R13: Numeric oscillator output equals initial frequency times one plus offset/2^32.
// R14: Offset resets to 0x046AAAAB, correcting master clock against 25 MHz.
// R15: Host keeps the offset within plus or minus five percent.
// R16: Host programs positive offset for slow oscillators, negative for fast ones.
// R17: Page register bit 0 maps the seven-bit address onto lower or upper page.
// R18: Multi-byte registers use consecutive bytes and commit once all are written.
`timescale 1ns/1ns
`include "sroff_params.svh"
module sroff_regs #(
    parameter int unsigned SHORT_CYCLES = `SROFF_LOCK_SHORT_CYC,
    parameter int unsigned LONG_CYCLES  = `SROFF_LOCK_LONG_CYC
)(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Host byte port
    input  wire logic        host_wr_strobe,
    input  wire logic        host_rd_strobe,
    input  wire logic [6:0]  host_addr,
    input  wire logic [7:0]  host_wdata,
    output logic      [7:0]  host_rdata,
    output logic             host_rdata_valid,
    // Synthesizer control
    output logic             first_synth_pll_choice,
    output logic             second_synth_pll_choice,
    output logic      [1:0]  synth_out_enable,
    output logic      [15:0] second_synth_ratio_top,
    output logic      [15:0] second_synth_ratio_bottom,
    output logic             ratio_update_pulse,
    // Central frequency offset
    output logic      [31:0] oscillator_trim,
    output logic             trim_update_pulse,
    // PLL lock
    input  wire logic [1:0]  phase_ok_1us_pin,
    input  wire logic [1:0]  phase_ok_10us_pin,
    output logic      [1:0]  pll_locked
);

    // ==============================================================
    // Address decode helpers
    function automatic logic in_word(input logic [6:0] addr, input logic [6:0] base);
        logic [6:0] diff;
        diff    = addr - base;
        in_word = (diff < 7'h04);
    endfunction

    // Byte lane, most significant byte at the lowest address
    function automatic logic [1:0] word_lane(input logic [6:0] addr,
                                             input logic [6:0] base);
        logic [6:0] diff;
        diff      = addr - base;
        word_lane = 2'h3 - diff[1:0];
    endfunction

    function automatic logic [31:0] put_byte(input logic [31:0] word,
                                             input logic [1:0]  lane,
                                             input logic [7:0]  data);
        logic [31:0] w;
        w                 = word;
        w[lane * 8 +: 8]  = data;
        put_byte          = w;
    endfunction

    // ==============================================================
    // Paged access qualification
    logic [7:0] page_reg;
    logic       page_hit;
    logic       low_page;
    logic       wr_low;

    assign page_hit = (host_addr == `SROFF_PAGE_ADDR); // R17
    assign low_page = !page_reg[`SROFF_PAGE_BIT]; // R17
    assign wr_low   = host_wr_strobe && low_page && !page_hit;

    // Page register, reachable from either page
    always_ff @(posedge core_clk)
    begin
        if (reset)
            page_reg <= `SROFF_PAGE_RST;
        else if (host_wr_strobe && page_hit)
            page_reg <= host_wdata; // R17
    end

    // ==============================================================
    // Single-byte registers
    logic [7:0] route_reg;
    logic [7:0] gate_reg;
    logic [7:0] locksel_reg;

    // Reserved bits are stored as written so defaults read back
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            route_reg   <= `SROFF_ROUTE_RST;
            gate_reg    <= `SROFF_GATE_RST;
            locksel_reg <= `SROFF_LOCKSEL_RST;
        end
        else if (wr_low)
        begin
            if (host_addr == `SROFF_ROUTE_ADDR)
                route_reg <= host_wdata; // R4 R5 R6
            if (host_addr == `SROFF_GATE_ADDR)
                gate_reg <= host_wdata; // R7
            if (host_addr == `SROFF_LOCKSEL_ADDR)
                locksel_reg <= host_wdata; // R8 R9
        end
    end

    // ==============================================================
    // Rate ratio: shadow bytes, commit when all four arrive
    logic        ratio_hit;
    logic [1:0]  ratio_lane;
    logic [3:0]  ratio_mask_reg;
    logic [31:0] ratio_shadow_reg;
    logic [31:0] ratio_reg;
    logic        ratio_pulse_reg;

    assign ratio_hit  = wr_low && in_word(host_addr, `SROFF_RATIO_ADDR);
    assign ratio_lane = word_lane(host_addr, `SROFF_RATIO_ADDR);

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ratio_shadow_reg <= `SROFF_RATIO_RST;
            ratio_reg        <= `SROFF_RATIO_RST; // R3
            ratio_mask_reg   <= 4'h0;
            ratio_pulse_reg  <= 1'b0;
        end
        else
        begin
            ratio_pulse_reg <= 1'b0;
            if (ratio_hit)
            begin
                ratio_shadow_reg <= put_byte(ratio_shadow_reg, ratio_lane, host_wdata);
                if ((ratio_mask_reg | (4'h1 << ratio_lane)) == 4'hF)
                begin
                    ratio_reg       <= put_byte(ratio_shadow_reg, ratio_lane,
                                                host_wdata); // R18
                    ratio_mask_reg  <= 4'h0;
                    ratio_pulse_reg <= 1'b1;
                end
                else
                    ratio_mask_reg <= ratio_mask_reg | (4'h1 << ratio_lane); // R18
            end
        end
    end

    // ==============================================================
    // Central frequency offset: same commit scheme
    logic        trim_hit;
    logic [1:0]  trim_lane;
    logic [3:0]  trim_mask_reg;
    logic [31:0] trim_shadow_reg;
    logic [31:0] trim_reg;
    logic        trim_pulse_reg;

    assign trim_hit  = wr_low && in_word(host_addr, `SROFF_TRIM_ADDR);
    assign trim_lane = word_lane(host_addr, `SROFF_TRIM_ADDR);

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            trim_shadow_reg <= `SROFF_TRIM_RST;
            trim_reg        <= `SROFF_TRIM_RST; // R14
            trim_mask_reg   <= 4'h0;
            trim_pulse_reg  <= 1'b0;
        end
        else
        begin
            trim_pulse_reg <= 1'b0;
            if (trim_hit)
            begin
                trim_shadow_reg <= put_byte(trim_shadow_reg, trim_lane, host_wdata);
                if ((trim_mask_reg | (4'h1 << trim_lane)) == 4'hF)
                begin
                    trim_reg       <= put_byte(trim_shadow_reg, trim_lane,
                                               host_wdata); // R18 R11
                    trim_mask_reg  <= 4'h0;
                    trim_pulse_reg <= 1'b1;
                end
                else
                    trim_mask_reg <= trim_mask_reg | (4'h1 << trim_lane); // R18
            end
        end
    end

    // ==============================================================
    // Lock qualification
    sroff_lock_if lock_bus ();

    assign lock_bus.criterion[0] =
        sroff_pkg::sroff_crit_type'(locksel_reg[`SROFF_LOCK0_LSB +: 2]); // R8
    assign lock_bus.criterion[1] =
        sroff_pkg::sroff_crit_type'(locksel_reg[`SROFF_LOCK1_LSB +: 2]); // R9

    sroff_lock_qual #(
        .SHORT_CYCLES (SHORT_CYCLES),
        .LONG_CYCLES  (LONG_CYCLES)
    ) u_lock_qual (
        .core_clk          (core_clk),
        .reset             (reset),
        .phase_ok_1us_pin  (phase_ok_1us_pin),
        .phase_ok_10us_pin (phase_ok_10us_pin),
        .lk                (lock_bus.qual)
    );

    // Lock indicator registered for the pll_locked output
    logic [1:0] locked_reg;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            locked_reg <= 2'h0;
        else
            locked_reg <= lock_bus.locked; // R10
    end

    // ==============================================================
    // Read path, one cycle after the strobe
    logic [7:0] rdata_reg;
    logic       rvalid_reg;
    logic [7:0] rdata_next;

    always_comb
    begin
        rdata_next = 8'h00;
        if (page_hit)
            rdata_next = page_reg;
        else if (low_page)
        begin
            if (in_word(host_addr, `SROFF_RATIO_ADDR))
                rdata_next = ratio_reg[word_lane(host_addr, `SROFF_RATIO_ADDR) * 8 +: 8];
            else if (in_word(host_addr, `SROFF_TRIM_ADDR))
                rdata_next = trim_reg[word_lane(host_addr, `SROFF_TRIM_ADDR) * 8 +: 8];
            else if (host_addr == `SROFF_ROUTE_ADDR)
                rdata_next = route_reg;
            else if (host_addr == `SROFF_GATE_ADDR)
                rdata_next = gate_reg;
            else if (host_addr == `SROFF_LOCKSEL_ADDR)
                rdata_next = locksel_reg;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= host_rd_strobe;
            if (host_rd_strobe)
                rdata_reg <= rdata_next;
        end
    end

    // ==============================================================
    // Outputs, all taken from flip-flops
    assign host_rdata                = rdata_reg;
    assign host_rdata_valid          = rvalid_reg;
    assign first_synth_pll_choice    = route_reg[`SROFF_ROUTE_S0_BIT]; // R4
    assign second_synth_pll_choice   = route_reg[`SROFF_ROUTE_S1_BIT]; // R5
    assign synth_out_enable          = gate_reg[`SROFF_GATE_LSB +: 2]; // R7
    // Ratio fields scale base frequency times multiplier times 16
    assign second_synth_ratio_top    = ratio_reg[`SROFF_RATIO_TOP_LSB +: 16]; // R1 R2
    assign second_synth_ratio_bottom = ratio_reg[`SROFF_RATIO_BOT_LSB +: 16]; // R1 R2
    assign ratio_update_pulse        = ratio_pulse_reg;
    // One word steers all four synthesizers, also in oscillator mode
    assign oscillator_trim           = trim_reg; // R12 R13
    assign trim_update_pulse         = trim_pulse_reg;
    assign pll_locked                = locked_reg;

endmodule

// [pkg/sroff_lock_if.sv]
// Purpose: Carries lock criteria to the qualifier and lock state back
// Assumes: Both ends on core_clk
// Notes:   Index 0 is the first PLL, index 1 the second
`timescale 1ns/1ns
interface sroff_lock_if;
    sroff_pkg::sroff_crit_type criterion [2];
    logic [1:0]                locked;

    modport regs (output criterion, input  locked);
    modport qual (input  criterion, output locked);
endinterface

// [pkg/sroff_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the
//          synthesizer routing and offset register group
// Assumes: Byte-wide host port with a seven-bit address and one page bit
// Notes:   Multi-byte registers are stored most significant byte first
`ifndef SROFF_PARAMS_SVH
`define SROFF_PARAMS_SVH

// ==================================================================
// Register offsets (page 0, seven-bit host address)
`define SROFF_RATIO_ADDR       7'h5C
`define SROFF_ROUTE_ADDR       7'h70
`define SROFF_GATE_ADDR        7'h71
`define SROFF_LOCKSEL_ADDR     7'h72
`define SROFF_TRIM_ADDR        7'h73
`define SROFF_PAGE_ADDR        7'h7F

// ==================================================================
// Reset values
`define SROFF_RATIO_RST        32'h00010001
`define SROFF_ROUTE_RST        8'hE4
`define SROFF_GATE_RST         8'h03
`define SROFF_LOCKSEL_RST      8'hAA
`define SROFF_TRIM_RST         32'h046AAAAB
`define SROFF_PAGE_RST         8'h00

// ==================================================================
// Field positions
`define SROFF_RATIO_BOT_LSB    0
`define SROFF_RATIO_TOP_LSB    16
`define SROFF_ROUTE_S0_BIT     0
`define SROFF_ROUTE_S1_BIT     2
`define SROFF_GATE_LSB         0
`define SROFF_LOCK0_LSB        0
`define SROFF_LOCK1_LSB        2
`define SROFF_PAGE_BIT         0

// ==================================================================
// Timing: clock rate and lock qualification windows
`define SROFF_CLK_HZ           125000000
`define SROFF_LOCK_SHORT_S     1
`define SROFF_LOCK_LONG_S      10
`define SROFF_LOCK_SHORT_CYC   (`SROFF_CLK_HZ * `SROFF_LOCK_SHORT_S)
`define SROFF_LOCK_LONG_CYC    (`SROFF_CLK_HZ * `SROFF_LOCK_LONG_S)

`endif

// [pkg/sroff_pkg.sv]
// Purpose: Types shared by the register group and its lock qualifier
// Assumes: Nothing beyond the params header
// Notes:   Constants live in the header, types live here
package sroff_pkg;

    // ==============================================================
    // Lock criterion codes
    typedef enum logic [1:0]
    {
        SROFF_CRIT_RSVD     = 2'b00,
        SROFF_CRIT_1US_1S   = 2'b01,
        SROFF_CRIT_10US_1S  = 2'b10,
        SROFF_CRIT_10US_10S = 2'b11
    } sroff_crit_type;

    // ==============================================================
    // Lock qualifier states
    typedef enum logic [0:0]
    {
        SROFF_QUAL_HUNT   = 1'b0,
        SROFF_QUAL_LOCKED = 1'b1
    } sroff_qual_type;

endpackage

// [verif/sroff_regs_asserts.sv]
// Purpose: Port checks of the routing, gate and offset registers
// Assumes: Page bit rebuilt here from host writes
// Notes:   Lock checks assume a short count of at least 2
`timescale 1ns/1ns
`include "sroff_params.svh"
module sroff_regs_asserts (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    // Host byte port
    input wire logic        host_wr_strobe,
    input wire logic        host_rd_strobe,
    input wire logic [6:0]  host_addr,
    input wire logic [7:0]  host_wdata,
    input wire logic [7:0]  host_rdata,
    input wire logic        host_rdata_valid,
    // Controls and lock
    input wire logic        first_synth_pll_choice,
    input wire logic        second_synth_pll_choice,
    input wire logic [1:0]  synth_out_enable,
    input wire logic [15:0] second_synth_ratio_top,
    input wire logic [15:0] second_synth_ratio_bottom,
    input wire logic        ratio_update_pulse,
    input wire logic [31:0] oscillator_trim,
    input wire logic        trim_update_pulse,
    input wire logic [1:0]  phase_ok_1us_pin,
    input wire logic [1:0]  phase_ok_10us_pin,
    input wire logic [1:0]  pll_locked
);
    // ====
    // Page bit as the host last set it
    logic page_reg;
    always_ff @(posedge core_clk)
        if (reset)
            page_reg <= 1'b0;
        else if (host_wr_strobe && host_addr == `SROFF_PAGE_ADDR)
            page_reg <= host_wdata[0];

    default clocking dc @(posedge core_clk); endclocking
    default disable iff (reset);

    // Read of one page 0 address
    sequence s_rd_at(logic [6:0] a);
        host_rd_strobe && !host_wr_strobe && !page_reg && host_addr == a;
    endsequence
    // First PLL lock going high
    sequence s_lock_rise;
        $rose(pll_locked[0]);
    endsequence

    a_rd_answer: assert property (host_rd_strobe |=> host_rdata_valid)
        else $error("read not answered");
    a_page1_blank: assert property (host_rd_strobe && page_reg
        && host_addr != `SROFF_PAGE_ADDR |=> host_rdata == 8'h00) else $error("page 1 not empty");
    a_gate_read: assert property (s_rd_at(`SROFF_GATE_ADDR)
        |=> host_rdata[1:0] == synth_out_enable) else $error("gate readback differs");
    a_route_write: assert property (host_wr_strobe && !page_reg
        && host_addr == `SROFF_ROUTE_ADDR |=> first_synth_pll_choice == $past(host_wdata[0])
        && second_synth_pll_choice == $past(host_wdata[2])) else $error("routing not taken");
    a_trim_cause: assert property (trim_update_pulse |-> $past(host_wr_strobe)
        && !$past(page_reg) && $past(host_addr) inside {[7'h73:7'h76]})
        else $error("offset commit without write");
    a_trim_hold: assert property (!trim_update_pulse && !$past(reset)
        |-> $stable(oscillator_trim)) else $error("offset moved without commit");
    a_ratio_hold: assert property (!ratio_update_pulse && !$past(reset)
        |-> $stable({second_synth_ratio_top, second_synth_ratio_bottom}))
        else $error("ratio moved without commit");
    a_lock_cause: assert property (s_lock_rise
        |-> $past(phase_ok_1us_pin[0] | phase_ok_10us_pin[0], 5)) else $error("lock without flag");
    a_lock_drop: assert property (!(phase_ok_1us_pin[1] | phase_ok_10us_pin[1]) [*6]
        |-> !pll_locked[1]) else $error("lock held without flag");
endmodule

bind sroff_regs sroff_regs_asserts u_chk (.*);

// [verif/sroff_regs_tb.sv]
// Purpose: Self-checking bench of the routing, gate and offset registers
// Assumes: Lock counts shortened to 4 and 12 cycles
// Notes:   Read bytes and word commits are checked from queues
`timescale 1ns/1ns
`include "sroff_params.svh"
module sroff_regs_tb;
    // ====
    // Stimulus, outputs and bookkeeping
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        host_wr_strobe = 1'b0;
    logic        host_rd_strobe = 1'b0;
    logic [6:0]  host_addr = 7'h00;
    logic [7:0]  host_wdata = 8'h00;
    logic [1:0]  phase_ok_1us_pin = 2'h0;
    logic [1:0]  phase_ok_10us_pin = 2'h0;
    logic [7:0]  host_rdata;
    logic        host_rdata_valid, first_synth_pll_choice, second_synth_pll_choice;
    logic        ratio_update_pulse, trim_update_pulse;
    logic [1:0]  synth_out_enable, pll_locked;
    logic [15:0] second_synth_ratio_top, second_synth_ratio_bottom;
    logic [31:0] oscillator_trim, v;
    int          err_total = 0;
    int          checks_done = 0;
    int          cycles = 0;
    integer      seed = 32'hDEE2;
    logic [7:0]  rq [$];
    logic [31:0] tq [$];
    logic [31:0] mq [$];
    // Lock rows: criterion byte, {1us pin, 10us pin, lock}, wait
    logic [7:0]  lsel  [5] = '{8'hA4, 8'hA9, 8'hA6, 8'hAE, 8'hAE};
    logic [3:0]  lrow  [5] = '{4'hE, 4'h9, 4'h5, 4'h5, 4'h7};
    int          lwait [5] = '{12, 12, 12, 9, 22};

    // Clock
    always #4 core_clk = ~core_clk;

    sroff_regs #(.SHORT_CYCLES(4), .LONG_CYCLES(12)) dut (.*);

    // ====
    // Verdict and compares
    task automatic report_and_stop();
        if (err_total == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp32({24'h0, got}, {24'h0, exp});
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t value %h want %h", $time, got, exp);
        end
    endtask

    // Host byte cycles, one per edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_wr_strobe <= 1'b1;
        host_rd_strobe <= 1'b0;
        host_addr      <= a;
        host_wdata     <= d;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        rq.push_back(e);
        host_wr_strobe <= 1'b0;
        host_rd_strobe <= 1'b1;
        host_addr      <= a;
        @(posedge core_clk);
    endtask
    task automatic idle(input int n);
        host_wr_strobe <= 1'b0;
        host_rd_strobe <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask
    // Word write; partial word stays hidden until the last lane
    task automatic wrw(input logic [6:0] a, input logic [31:0] d, input bit rev,
                       input logic [31:0] prev);
        int          l;
        logic [31:0] w;
        for (int i = 0; i < 4; i++)
        begin
            l = rev ? 3 - i : i;
            if (i == 3)
            begin
                idle(2);
                w = (a == `SROFF_TRIM_ADDR) ? oscillator_trim
                    : {second_synth_ratio_top, second_synth_ratio_bottom};
                cmp32(w, prev);
                if (a == `SROFF_TRIM_ADDR)
                    tq.push_back(d);
                else
                    mq.push_back(d);
            end
            wr(a + 7'(l), d[31 - 8 * l -: 8]);
        end
        idle(2);
    endtask

    // Result watcher
    always @(posedge core_clk)
    begin
        if (host_rdata_valid)
            cmp8(host_rdata, rq.size() > 0 ? rq.pop_front() : 8'hXX);
        if (trim_update_pulse)
            cmp32(oscillator_trim, tq.size() > 0 ? tq.pop_front() : 32'hX);
        if (ratio_update_pulse)
            cmp32({second_synth_ratio_top, second_synth_ratio_bottom},
                  mq.size() > 0 ? mq.pop_front() : 32'hX);
    end

    // Hang guard
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    // Main sequence
    initial
    begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        cmp32(oscillator_trim, `SROFF_TRIM_RST);
        cmp32(32'({first_synth_pll_choice, second_synth_pll_choice, synth_out_enable}),
              32'h7);
        for (int i = 0; i < 4; i++)
        begin
            v = `SROFF_RATIO_RST;
            rd(`SROFF_RATIO_ADDR + 7'(i), v[31 - 8 * i -: 8]);
            v = `SROFF_TRIM_RST;
            rd(`SROFF_TRIM_ADDR + 7'(i), v[31 - 8 * i -: 8]);
        end
        rd(`SROFF_ROUTE_ADDR, 8'hE4);
        rd(`SROFF_GATE_ADDR, 8'h03);
        rd(`SROFF_LOCKSEL_ADDR, 8'hAA);
        for (int k = 0; k < 4; k++)
        begin
            v = $random(seed);
            wr(`SROFF_ROUTE_ADDR, {5'h1C, v[2], 1'b0, v[0]});
            wr(`SROFF_GATE_ADDR, 8'(k));
            idle(1);
            cmp32(32'({first_synth_pll_choice, second_synth_pll_choice}),
                  32'({v[0], v[2]}));
            cmp32(32'(synth_out_enable), 32'(k));
            rd(`SROFF_ROUTE_ADDR, {5'h1C, v[2], 1'b0, v[0]});
        end
        wr(`SROFF_PAGE_ADDR, 8'h01);
        rd(`SROFF_GATE_ADDR, 8'h00);
        wr(`SROFF_GATE_ADDR, 8'h00);
        rd(`SROFF_PAGE_ADDR, 8'h01);
        wr(`SROFF_PAGE_ADDR, 8'h00);
        rd(`SROFF_GATE_ADDR, 8'h03);
        v = $random(seed);
        wrw(`SROFF_TRIM_ADDR, {5'h00, v[26:0]}, 1'b0, `SROFF_TRIM_RST);
        wrw(`SROFF_TRIM_ADDR, -{5'h00, v[26:0]}, 1'b1, {5'h00, v[26:0]});
        wrw(`SROFF_RATIO_ADDR, v | 32'h1, 1'b1, `SROFF_RATIO_RST);
        reset <= 1'b1;
        idle(2);
        reset <= 1'b0;
        idle(1);
        cmp32(oscillator_trim, `SROFF_TRIM_RST);
        for (int r = 0; r < 5; r++)
        begin
            phase_ok_1us_pin  <= 2'h0;
            phase_ok_10us_pin <= 2'h0;
            wr(`SROFF_LOCKSEL_ADDR, lsel[r]);
            rd(`SROFF_LOCKSEL_ADDR, lsel[r]);
            idle(8);
            phase_ok_1us_pin  <= {2{lrow[r][3]}};
            phase_ok_10us_pin <= {2{lrow[r][2]}};
            idle(lwait[r]);
            cmp32(32'(pll_locked), 32'(lrow[r][1:0]));
        end
        idle(3);
        cmp32(32'(rq.size() + tq.size() + mq.size()), 32'h0);
        report_and_stop();
    end
endmodule
